// file: include/ssx_pkg.sv
package ssx_pkg;

    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SSX_OP_NONE         = 4'h0,
        SSX_OP_LIT_MINUS    = 4'h1,
        SSX_OP_FILE_MINUS   = 4'h2,
        SSX_OP_FILE_BORROW  = 4'h3,
        SSX_OP_NIBBLE_EXCH  = 4'h4,
        SSX_OP_DIR_LOAD     = 4'h5,
        SSX_OP_LIT_XOR      = 4'h6,
        SSX_OP_FILE_XOR     = 4'h7
    } ssx_op_t;

    // ------------------------------------------------------------
    // widths and constants
    // ------------------------------------------------------------
    localparam int          SSX_DATA_W      = 8;
    localparam int          SSX_ADDR_W      = 7;
    localparam logic [6:0]  SSX_DIR_A_SEL   = 7'h05;
    localparam logic [6:0]  SSX_DIR_B_SEL   = 7'h06;
    localparam logic [6:0]  SSX_DIR_C_SEL   = 7'h07;
    localparam logic [7:0]  SSX_ACC_RST     = 8'h00;
    localparam logic [7:0]  SSX_DIR_RST     = 8'hff;
    localparam logic [6:0]  SSX_WADDR_RST   = 7'h00;
    localparam logic [7:0]  SSX_WDATA_RST   = 8'h00;
    localparam logic        SSX_FLAG_RST    = 1'b0;
    localparam logic        SSX_DEST_ACC    = 1'b0;

endpackage : ssx_pkg

// file: design/ssx_subtractor.sv
`timescale 1ns/10ps
// minuend - subtrahend - borrow, with full and low-nibble no-borrow flags
module ssx_subtractor
    import ssx_pkg::*;
(
    input  wire logic [7:0] minuend_in,
    input  wire logic [7:0] subtrahend_in,
    input  wire logic       borrow_in,
    output logic      [7:0] diff_out,
    output logic            no_borrow_out,
    output logic            nibble_no_borrow_out
);
    logic [8:0] full_w;
    logic [4:0] low_w;

    always_comb
    begin
        full_w               = {1'b0, minuend_in} + {1'b0, ~subtrahend_in} + {8'h00, ~borrow_in};
        low_w                = {1'b0, minuend_in[3:0]} + {1'b0, ~subtrahend_in[3:0]}
                               + {4'h0, ~borrow_in};
        diff_out             = full_w[7:0];
        no_borrow_out        = full_w[8];
        nibble_no_borrow_out = low_w[4];
    end

endmodule : ssx_subtractor

// file: design/ssx_alu.sv
`timescale 1ns/10ps
// Functional notes
// - literal minus accumulator, carry and nibble flags
// - file minus accumulator, carry and nibble flags
// - borrow subtract uses inverted carry as borrow
// - nibble exchange swaps halves, flags untouched
// - nibble exchange result steered by destination bit
// - operand 5/6/7 loads port A/B/C direction
// - literal xor into accumulator, zero only
// - file xor steered, zero flag only
module ssx_alu
    import ssx_pkg::*;
(
    input  wire logic                    core_clk_in,
    input  wire logic                    rst_n_in,
    input  wire logic                    op_valid_in,
    input  wire ssx_pkg::ssx_op_t        op_in,
    input  wire logic [7:0]              literal_in,
    input  wire logic [6:0]              file_addr_in,
    input  wire logic                    dest_sel_in,
    input  wire logic [7:0]              file_data_in,
    output logic      [7:0]              acc_out,
    output logic                         carry_out,
    output logic                         nibble_borrow_flag_out,
    output logic                         zero_out,
    output logic                         file_we_out,
    output logic      [6:0]              file_wr_addr_out,
    output logic      [7:0]              file_wr_data_out,
    output logic      [7:0]              port_a_direction_out,
    output logic      [7:0]              port_b_direction_out,
    output logic      [7:0]              port_c_direction_out
);
    import ssx_pkg::*;

    // ------------------------------------------------------------
    // arithmetic
    // ------------------------------------------------------------
    logic [7:0] sub_min_w;
    logic       sub_bin_w;
    logic [7:0] diff_w;
    logic       nb_w;
    logic       nnb_w;

    always_comb
    begin
        sub_min_w = (op_in == SSX_OP_LIT_MINUS) ? literal_in : file_data_in;
        sub_bin_w = (op_in == SSX_OP_FILE_BORROW) ? ~carry_out : 1'b0;
    end

    ssx_subtractor u_sub (
        .minuend_in           (sub_min_w),
        .subtrahend_in        (acc_out),
        .borrow_in            (sub_bin_w),
        .diff_out             (diff_w),
        .no_borrow_out        (nb_w),
        .nibble_no_borrow_out (nnb_w)
    );

    // ------------------------------------------------------------
    // result select and state update
    // ------------------------------------------------------------
    logic [7:0] acc_d, acc_q;
    logic       c_d, c_q, dc_d, dc_q, z_d, z_q;
    logic       we_d, we_q;
    logic [6:0] wa_d, wa_q;
    logic [7:0] wd_d, wd_q;
    logic [7:0] res_w;
    logic       to_file_w;
    logic       arith_w;
    logic       zflag_w;
    logic       write_w;

    always_comb
    begin
        res_w     = 8'h00;
        arith_w   = 1'b0;
        zflag_w   = 1'b0;
        write_w   = 1'b0;
        to_file_w = 1'b0;
        unique case (op_in)
            SSX_OP_LIT_MINUS:
            begin
                res_w   = diff_w;
                arith_w = 1'b1;
                zflag_w = 1'b1;
                write_w = 1'b1;
            end
            SSX_OP_FILE_MINUS, SSX_OP_FILE_BORROW:
            begin
                res_w     = diff_w;
                arith_w   = 1'b1;
                zflag_w   = 1'b1;
                write_w   = 1'b1;
                to_file_w = (dest_sel_in != SSX_DEST_ACC);
            end
            SSX_OP_NIBBLE_EXCH:
            begin
                res_w     = {file_data_in[3:0], file_data_in[7:4]};
                write_w   = 1'b1;
                to_file_w = (dest_sel_in != SSX_DEST_ACC);
            end
            SSX_OP_LIT_XOR:
            begin
                res_w   = acc_out ^ literal_in;
                zflag_w = 1'b1;
                write_w = 1'b1;
            end
            SSX_OP_FILE_XOR:
            begin
                res_w     = acc_out ^ file_data_in;
                zflag_w   = 1'b1;
                write_w   = 1'b1;
                to_file_w = (dest_sel_in != SSX_DEST_ACC);
            end
            default:
            begin
                res_w = 8'h00;
            end
        endcase

        acc_d  = acc_q;
        c_d    = c_q;
        dc_d   = dc_q;
        z_d    = z_q;
        we_d   = 1'b0;
        wa_d   = wa_q;
        wd_d   = wd_q;
        if (op_valid_in)
        begin
            if (write_w && to_file_w)
            begin
                we_d = 1'b1;
                wa_d = file_addr_in;
                wd_d = res_w;
            end
            else if (write_w)
            begin
                acc_d = res_w;
            end
            if (arith_w)
            begin
                c_d  = nb_w;
                dc_d = nnb_w;
            end
            if (zflag_w)
            begin
                z_d = (res_w == 8'h00);
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            acc_q  <= SSX_ACC_RST;
            c_q    <= SSX_FLAG_RST;
            dc_q   <= SSX_FLAG_RST;
            z_q    <= SSX_FLAG_RST;
            we_q   <= 1'b0;
            wa_q   <= SSX_WADDR_RST;
            wd_q   <= SSX_WDATA_RST;
        end
        else
        begin
            acc_q  <= acc_d;
            c_q    <= c_d;
            dc_q   <= dc_d;
            z_q    <= z_d;
            we_q   <= we_d;
            wa_q   <= wa_d;
            wd_q   <= wd_d;
        end
    end

    // ------------------------------------------------------------
    // port direction registers, one per port
    // ------------------------------------------------------------
    for (genvar g = 0; g < 3; g++)
    begin : g_dir
        localparam logic [6:0] PORT_SEL = (g == 0) ? SSX_DIR_A_SEL
                                        : (g == 1) ? SSX_DIR_B_SEL : SSX_DIR_C_SEL;
        logic [7:0] dir_d;
        logic [7:0] dir_q;

        always_comb
        begin
            dir_d = dir_q;
            if (op_valid_in && op_in == SSX_OP_DIR_LOAD && file_addr_in == PORT_SEL)
            begin
                dir_d = acc_q;
            end
        end

        always_ff @(posedge core_clk_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
            begin
                dir_q <= SSX_DIR_RST;
            end
            else
            begin
                dir_q <= dir_d;
            end
        end
    end

    assign acc_out                = acc_q;
    assign carry_out              = c_q;
    assign nibble_borrow_flag_out = dc_q;
    assign zero_out               = z_q;
    assign file_we_out            = we_q;
    assign file_wr_addr_out       = wa_q;
    assign file_wr_data_out       = wd_q;
    assign port_a_direction_out   = g_dir[0].dir_q;
    assign port_b_direction_out   = g_dir[1].dir_q;
    assign port_c_direction_out   = g_dir[2].dir_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_lit_sub_value: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        op_valid_in && op_in == SSX_OP_LIT_MINUS |=>
        acc_out == $past(literal_in) - $past(acc_out)
        && carry_out == ($past(acc_out) <= $past(literal_in))
        && nibble_borrow_flag_out == ($past(acc_out[3:0]) <= $past(literal_in[3:0])))
        else $error("literal minus accumulator wrong");

    a_file_sub_flags: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        op_valid_in && op_in == SSX_OP_FILE_MINUS |=>
        carry_out == ($past(acc_out) <= $past(file_data_in))
        && nibble_borrow_flag_out == ($past(acc_out[3:0]) <= $past(file_data_in[3:0])))
        else $error("file minus accumulator flags wrong");

    a_borrow_sub_value: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        op_valid_in && op_in == SSX_OP_FILE_BORROW && !dest_sel_in |=>
        acc_out == 8'($past(file_data_in) - $past(acc_out) - {7'h00, ~$past(carry_out)}))
        else $error("borrow subtract wrong");

    a_dest_file_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        op_valid_in && dest_sel_in && op_in == SSX_OP_FILE_XOR |=>
        file_we_out && file_wr_addr_out == $past(file_addr_in) && $stable(acc_out))
        else $error("file destination not written");

    a_swap_flags_kept: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        op_valid_in && op_in == SSX_OP_NIBBLE_EXCH |=>
        $stable(carry_out) && $stable(zero_out) && $stable(nibble_borrow_flag_out))
        else $error("nibble exchange touched flags");

    a_swap_to_acc: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        op_valid_in && op_in == SSX_OP_NIBBLE_EXCH && !dest_sel_in |=>
        acc_out == {$past(file_data_in[3:0]), $past(file_data_in[7:4])} && !file_we_out)
        else $error("nibble exchange to accumulator wrong");

    a_dir_load_b: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        op_valid_in && op_in == SSX_OP_DIR_LOAD && file_addr_in == SSX_DIR_B_SEL |=>
        port_b_direction_out == $past(acc_out) && $stable(port_a_direction_out))
        else $error("port b direction load wrong");

    a_lit_xor_flags: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        op_valid_in && op_in == SSX_OP_LIT_XOR |=>
        acc_out == ($past(acc_out) ^ $past(literal_in)) && $stable(carry_out))
        else $error("literal xor wrong");

    a_file_xor_zero: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        op_valid_in && op_in == SSX_OP_FILE_XOR |=>
        zero_out == (($past(acc_out) ^ $past(file_data_in)) == 8'h00)
        && $stable(nibble_borrow_flag_out))
        else $error("file xor zero flag wrong");

    a_zero_on_result: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        op_valid_in && op_in == SSX_OP_LIT_MINUS && literal_in == acc_out |=> zero_out)
        else $error("zero flag not set");

endmodule : ssx_alu

// file: dv/ssx_file_model.sv
`timescale 1ns/10ps
module ssx_file_model
    import ssx_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic [6:0] rd_addr_in,
    input  wire logic       we_in,
    input  wire logic [6:0] wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    output logic      [7:0] rd_data_out
);
    logic [7:0] mem [128];

    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 37 + 17);
    end

    // forward a write pulse that lands in the cycle of the read
    assign rd_data_out = (we_in && wr_addr_in == rd_addr_in) ? wr_data_in : mem[rd_addr_in];

    always @(posedge core_clk_in)
        if (we_in) mem[wr_addr_in] <= wr_data_in;
endmodule : ssx_file_model

// file: dv/sub_swap_xor_alu_ops_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
    begin \
        cmp_count++; \
        if ((got) !== (ex)) \
        begin \
            mismatches++; \
            $display("BAD %s exp %h got %h", nm, ex, got); \
        end \
    end
module sub_swap_xor_alu_ops_tb_top;
    import ssx_pkg::*;
    logic             clk, rst_n, valid, dest, we, c, nb, z;
    ssx_pkg::ssx_op_t op;
    logic [7:0]       lit, fdata, acc, wdata, dir_a, dir_b, dir_c;
    logic [6:0]       addr, waddr;
    logic [7:0]       m_acc, m_mem [128], m_dir [3];
    logic             m_c, m_nb, m_z;
    int               mismatches, cmp_count;

    ssx_alu u_ssx_alu (.core_clk_in(clk), .rst_n_in(rst_n), .op_valid_in(valid), .op_in(op),
        .literal_in(lit), .file_addr_in(addr), .dest_sel_in(dest), .file_data_in(fdata),
        .acc_out(acc), .carry_out(c), .nibble_borrow_flag_out(nb), .zero_out(z),
        .file_we_out(we), .file_wr_addr_out(waddr), .file_wr_data_out(wdata),
        .port_a_direction_out(dir_a), .port_b_direction_out(dir_b),
        .port_c_direction_out(dir_c));
    ssx_file_model u_ssx_file_model (.core_clk_in(clk), .rd_addr_in(addr), .we_in(we),
        .wr_addr_in(waddr), .wr_data_in(wdata), .rd_data_out(fdata));

    // ------------------------------------------------------------
    // reference and helpers
    // ------------------------------------------------------------
    function automatic logic [9:0] sub_ref(input logic [7:0] a, input logic [7:0] b,
                                           input logic ci);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, a} + {1'b0, ~b} + 9'(ci);
        n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(ci);
        return {s[8], n[4], s[7:0]};
    endfunction : sub_ref

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // one instruction; entered just after a rising edge
    task automatic run_op(input logic [3:0] o, input logic [7:0] k, input logic [6:0] f,
                          input logic d);
        logic [7:0] res;
        logic       wr;
        valid = 1'b1;
        op    = ssx_op_t'(o);
        lit   = k;
        addr  = f;
        dest  = d;
        wr    = 1'b0;
        res   = m_acc;
        case (o)
            4'h1: {m_c, m_nb, res} = sub_ref(k, m_acc, 1'b1);
            4'h2: {m_c, m_nb, res} = sub_ref(m_mem[f], m_acc, 1'b1);
            4'h3: {m_c, m_nb, res} = sub_ref(m_mem[f], m_acc, m_c);
            4'h4: res = {m_mem[f][3:0], m_mem[f][7:4]};
            4'h5: if (f >= 7'h05 && f <= 7'h07) m_dir[f - 7'h05] = m_acc;
            4'h6: res = m_acc ^ k;
            4'h7: res = m_acc ^ m_mem[f];
            default: ;
        endcase
        if (o inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7})
            m_z = (res == 8'h00);
        if (o inside {4'h2, 4'h3, 4'h4, 4'h7} && d)
            wr = 1'b1;
        else if (o inside {[4'h1:4'h4], 4'h6, 4'h7})
            m_acc = res;
        @(posedge clk);
        #1;
        `CHK("acc", m_acc, acc)
        `CHK("carry", m_c, c)
        `CHK("nibble flag", m_nb, nb)
        `CHK("zero", m_z, z)
        `CHK("file we", wr, we)
        `CHK("dir a", m_dir[0], dir_a)
        `CHK("dir b", m_dir[1], dir_b)
        `CHK("dir c", m_dir[2], dir_c)
        if (wr)
        begin
            m_mem[f] = res;
            `CHK("wr addr", f, waddr)
            `CHK("wr data", res, wdata)
        end
    endtask : run_op

    // ------------------------------------------------------------
    // clock, watchdog and sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        #200000;
        mismatches++;
        report_and_stop();
    end

    initial
    begin
        {rst_n, valid, dest, lit, addr} = '0;
        op = SSX_OP_NONE;
        {m_acc, m_c, m_nb, m_z} = '0;
        m_dir = '{8'hff, 8'hff, 8'hff};
        for (int i = 0; i < 128; i++)
            m_mem[i] = 8'(i * 37 + 17);
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        `CHK("acc rst", 8'h00, acc)
        `CHK("dir a rst", 8'hff, dir_a)
        run_op(4'h6, 8'h3c, 7'h00, 1'b0);
        run_op(4'h1, 8'h3c, 7'h00, 1'b0);
        run_op(4'h6, 8'h05, 7'h00, 1'b0);
        run_op(4'h1, 8'h04, 7'h00, 1'b0);
        run_op(4'h1, 8'h13, 7'h00, 1'b0);
        for (int i = 4; i <= 8; i++)
        begin
            run_op(4'h6, 8'(i * 17), 7'h00, 1'b0);
            run_op(4'h5, 8'h00, 7'(i), 1'b1);
        end
        run_op(4'h4, 8'h00, 7'h20, 1'b0);
        run_op(4'h4, 8'h00, 7'h20, 1'b1);
        run_op(4'h2, 8'h00, 7'h0a, 1'b1);
        run_op(4'h7, 8'h00, 7'h0a, 1'b0);
        run_op(4'h7, 8'h00, 7'h0b, 1'b1);
        run_op(4'h2, 8'h00, 7'h0c, 1'b0);
        run_op(4'h6, m_acc, 7'h00, 1'b0);
        run_op(4'h1, 8'h00, 7'h00, 1'b0);
        run_op(4'h3, 8'h00, 7'h1e, 1'b0);
        run_op(4'h1, 8'h00, 7'h00, 1'b0);
        run_op(4'h3, 8'h00, 7'h1f, 1'b1);
        run_op(4'h3, 8'h00, 7'h1f, 1'b0);
        foreach (m_dir[i])
            run_op(4'(i * 7 + 1), 8'h55, 7'h05, 1'b1);
        run_op(4'hf, 8'h55, 7'h06, 1'b1);
        // mid-run reset, then a borrow subtract with carry clear
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        {m_acc, m_c, m_nb, m_z} = '0;
        m_dir = '{8'hff, 8'hff, 8'hff};
        #1;
        `CHK("acc rst2", 8'h00, acc)
        `CHK("dir c rst2", 8'hff, dir_c)
        `CHK("file we rst2", 1'b0, we)
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        run_op(4'h3, 8'h00, 7'h1e, 1'b1);
        run_op(4'h7, 8'h00, 7'h1e, 1'b0);
        report_and_stop();
    end
endmodule : sub_swap_xor_alu_ops_tb_top
